// ===== aut_core_model.sv
module aut_core_model (
  // Clock
  input wire logic sys_clk_i,
  // Requests toward the translation unit
  output logic fetch_req_o,
  output logic [31:0] fetch_ea_o,
  output logic data_req_o,
  output logic data_store_o,
  output logic [31:0] data_ea_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines at time zero
  initial begin
    {fetch_req_o, data_req_o, data_store_o} = 3'h0;
    fetch_ea_o = 32'h0;
    data_ea_o = 32'h0;
  end
  // Hold one request across its taking edge; caller samples the answer
  task automatic issue(input bit d, input bit st, input logic [31:0] ea);
    fetch_req_o = !d;
    data_req_o = d;
    data_store_o = st;
    fetch_ea_o = d ? ~fetch_ea_o : ea;
    data_ea_o = d ? ea : ~data_ea_o;
    @(negedge sys_clk_i);
  endtask
  // Released lines show the inverse of the last address, never stale values
  task automatic idle();
    fetch_req_o = 1'b0;
    data_req_o = 1'b0;
    fetch_ea_o = ~fetch_ea_o;
    data_ea_o = ~data_ea_o;
  endtask
endmodule

// ===== aut_defs.svh
// Functional notes
// (R1) Map every effective address to a physical one and check its access protection.
// (R2) Translate only instruction fetches and load/store data requests.
// (R3) Page table size is a power of two, base aligned; hashing ORs base bits.
// (R4) An entry group is eight 8-byte entries, 64 bytes; group addresses start searches.
// (R5) Fetch translation only while instr_xlate_en set; data only while data_xlate_en set.
// (R6) 4 Gbyte logical space, fixed 4-Kbyte pages, 256-Mbyte segments.
// (R7) Block translations cover software-chosen sizes from 128 Kbyte to 256 Mbyte.
// (R8) Form a 52-bit virtual address, then a 32-bit physical address via hashing.
// (R9) Misses and protection violations are reported as exceptions, never resolved silently.
// (R10) Cache lookup runs beside the access, so a hit costs no extra cycle.
// (R11) Separate instruction and data translation caches, 64 entries, two-way set associative.
// (R12) On a miss supply primary and secondary group addresses to the software search.
// (R13) Supervisor may invalidate entries selectively; consistency with memory is software's job.
// (R14) Independent four-entry block arrays for instructions and data, loaded by software.
// (R15) Fetch miss in the instruction cache raises vector 01000.
// (R16) Load miss in the data cache raises vector 01100.
// (R17) Store miss, or store hit with change bit clear, raises vector 01200.
// (R18) Valid block match beats page result; refill replaces least recently used way.
`ifndef AUT_DEFS_SVH
`define AUT_DEFS_SVH
// Address fields
`define AUT_PAGE_KB 4
`define AUT_EA_PG_LO 12
`define AUT_SEG_MB 256
`define AUT_SEG_LO 28
`define AUT_SEG_CNT 16
`define AUT_BLK_LO 17
`define AUT_BLK_MIN_KB 128
`define AUT_BL_W 11
`define AUT_BAT_CNT 4
`define AUT_VSID_W 24
`define AUT_VA_W 52
`define AUT_RPN_W 20
// Translation cache shape
`define AUT_TC_ENTRIES 64
`define AUT_TC_WAYS 2
`define AUT_TC_SETS 32
`define AUT_SET_W 5
`define AUT_TAG_W 35
// Hashed table
`define AUT_GRP_BYTES 64
`define AUT_GRP_LO 6
`define AUT_HASH_W 19
`define AUT_HMASK_W 9
// Exception vectors
`define AUT_VEC_IMISS 20'h01000
`define AUT_VEC_DLMISS 20'h01100
`define AUT_VEC_DSMISS 20'h01200
// Protection codes
`define AUT_PP_NONE 2'h0
`define AUT_PP_URO 2'h1
`define AUT_PP_RO 2'h3
// Reset values
`define AUT_PA_RST 32'h0000_0000
`define AUT_VEC_RST 20'h00000
`endif

// ===== aut_pkg.sv
package aut_pkg;
  // Block array entry
  typedef struct packed {
    logic [14:0] bepi;
    logic [10:0] bl;
    logic [14:0] brpn;
    logic vs;
    logic vp;
    logic [1:0] pp;
  } aut_bat_t;
  // Which side produced the captured miss
  typedef enum logic [2:0] {
    AUT_SRC_NONE = 3'b001,
    AUT_SRC_FETCH = 3'b010,
    AUT_SRC_DATA = 3'b100
  } aut_src_t;
  typedef logic [19:0] aut_vec_t;
endpackage

// ===== aut_xlate_cache.sv
`include "aut_defs.svh"
module aut_xlate_cache (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Lookup
  input wire logic lk_req_i,
  input wire logic [`AUT_VSID_W-1:0] lk_vsid_i,
  input wire logic [31:0] lk_ea_i,
  output logic lk_hit_o,
  output logic [`AUT_RPN_W-1:0] lk_rpn_o,
  output logic lk_chg_o,
  output logic [1:0] lk_pp_o,
  // Entry load
  input wire logic wr_i,
  input wire logic [`AUT_VSID_W-1:0] wr_vsid_i,
  input wire logic [31:0] wr_ea_i,
  input wire logic [`AUT_RPN_W-1:0] wr_rpn_i,
  input wire logic wr_chg_i,
  input wire logic [1:0] wr_pp_i,
  // Selective invalidate
  input wire logic inv_i,
  input wire logic [31:0] inv_ea_i
);
  localparam int SETS = `AUT_TC_SETS;
  localparam int WAYS = `AUT_TC_WAYS;
  typedef logic [`AUT_TAG_W-1:0] tag_t;

  // Set index and tag of an address
  function automatic logic [`AUT_SET_W-1:0] set_of(input logic [31:0] ea);
    return ea[`AUT_EA_PG_LO +: `AUT_SET_W];
  endfunction
  function automatic tag_t tag_of(input logic [`AUT_VSID_W-1:0] vs, input logic [31:0] ea);
    return {vs, ea[`AUT_SEG_LO-1:`AUT_EA_PG_LO+`AUT_SET_W]};
  endfunction

  logic [WAYS-1:0] vld_r [SETS];
  logic [WAYS-1:0] vld_nxt [SETS];
  logic [WAYS-1:0] chg_r [SETS];
  logic [WAYS-1:0] chg_nxt [SETS];
  tag_t tag_r [SETS][WAYS];
  tag_t tag_nxt [SETS][WAYS];
  logic [`AUT_RPN_W-1:0] rpn_r [SETS][WAYS];
  logic [`AUT_RPN_W-1:0] rpn_nxt [SETS][WAYS];
  logic [1:0] pp_r [SETS][WAYS];
  logic [1:0] pp_nxt [SETS][WAYS];
  logic [SETS-1:0] lru_r;
  logic [SETS-1:0] lru_nxt;
  logic [WAYS-1:0] way_hit;
  logic [WAYS-1:0] wr_match;
  logic [`AUT_SET_W-1:0] lk_set;
  logic [`AUT_SET_W-1:0] wr_set;
  logic [`AUT_SET_W-1:0] inv_set;

  assign lk_set = set_of(lk_ea_i);
  assign wr_set = set_of(wr_ea_i);
  assign inv_set = set_of(inv_ea_i);

  // Parallel compare of both ways
  genvar w;
  generate
    for (w = 0; w < WAYS; w++) begin : g_way
      assign way_hit[w] = vld_r[lk_set][w] && (tag_r[lk_set][w] == tag_of(lk_vsid_i, lk_ea_i)); // [R10]
      assign wr_match[w] = vld_r[wr_set][w] && (tag_r[wr_set][w] == tag_of(wr_vsid_i, wr_ea_i));
    end
  endgenerate

  // Hit data, way 1 wins the mux
  assign lk_hit_o = |way_hit;
  assign lk_rpn_o = way_hit[1] ? rpn_r[lk_set][1] : rpn_r[lk_set][0];
  assign lk_chg_o = way_hit[1] ? chg_r[lk_set][1] : chg_r[lk_set][0];
  assign lk_pp_o = way_hit[1] ? pp_r[lk_set][1] : pp_r[lk_set][0];

  // Next contents: invalidate, then load, with replacement order
  always_comb begin
    logic wway;
    wway = 1'b0;
    vld_nxt = vld_r;
    chg_nxt = chg_r;
    tag_nxt = tag_r;
    rpn_nxt = rpn_r;
    pp_nxt = pp_r;
    lru_nxt = lru_r;
    if (lk_req_i && lk_hit_o) begin
      lru_nxt[lk_set] = ~way_hit[1]; // [R18]
    end
    if (inv_i) begin
      vld_nxt[inv_set] = '0; // [R13]
    end
    if (wr_i) begin
      wway = wr_match[1] ? 1'b1 : (wr_match[0] ? 1'b0 : lru_r[wr_set]); // [R18]
      vld_nxt[wr_set][wway] = 1'b1; // [R11]
      tag_nxt[wr_set][wway] = tag_of(wr_vsid_i, wr_ea_i);
      rpn_nxt[wr_set][wway] = wr_rpn_i;
      chg_nxt[wr_set][wway] = wr_chg_i;
      pp_nxt[wr_set][wway] = wr_pp_i;
      lru_nxt[wr_set] = ~wway;
    end
  end

  // Storage registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int s = 0; s < SETS; s++) begin
        vld_r[s] <= '0;
        chg_r[s] <= '0;
        for (int k = 0; k < WAYS; k++) begin
          tag_r[s][k] <= '0;
          rpn_r[s][k] <= '0;
          pp_r[s][k] <= '0;
        end
      end
      lru_r <= '0;
    end else begin
      vld_r <= vld_nxt;
      chg_r <= chg_nxt;
      tag_r <= tag_nxt;
      rpn_r <= rpn_nxt;
      pp_r <= pp_nxt;
      lru_r <= lru_nxt;
    end
  end

  // Invalidated set holds nothing afterwards when no load comes in the same cycle
  property p_inval;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (inv_i && !wr_i) |=> (vld_r[$past(inv_set)] == '0);
  endproperty
  a_inval: assert property (p_inval) else $error("set still valid after invalidate"); // [R13]
endmodule

// ===== aut_xlate_unit.sv
`include "aut_defs.svh"
module aut_xlate_unit #(
  // Protection fault vectors, plain defaults
  parameter aut_pkg::aut_vec_t IPROT_VEC = 20'h00400,
  parameter aut_pkg::aut_vec_t DPROT_VEC = 20'h00300
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Machine state bits
  input wire logic instr_xlate_en_i,
  input wire logic data_xlate_en_i,
  input wire logic user_mode_i,
  // Instruction fetch request and answer
  input wire logic fetch_req_i,
  input wire logic [31:0] fetch_ea_i,
  output logic fetch_ack_o,
  output logic [31:0] fetch_pa_o,
  output logic fetch_exc_o,
  output logic [19:0] fetch_vec_o,
  // Data request and answer
  input wire logic data_req_i,
  input wire logic data_store_i,
  input wire logic [31:0] data_ea_i,
  output logic data_ack_o,
  output logic [31:0] data_pa_o,
  output logic data_exc_o,
  output logic [19:0] data_vec_o,
  // Search assist
  output logic [31:0] grp_pri_o,
  output logic [31:0] grp_sec_o,
  output logic [`AUT_VA_W-1:0] miss_va_o,
  output logic miss_from_data_o,
  // Segment load
  input wire logic seg_we_i,
  input wire logic [3:0] seg_idx_i,
  input wire logic [`AUT_VSID_W-1:0] seg_vsid_i,
  // Page table location
  input wire logic [15:0] htab_base_i,
  input wire logic [`AUT_HMASK_W-1:0] htab_mask_i,
  // Block array load
  input wire logic bat_we_i,
  input wire logic bat_data_i,
  input wire logic [1:0] bat_idx_i,
  input wire logic [14:0] bat_bepi_i,
  input wire logic [10:0] bat_bl_i,
  input wire logic [14:0] bat_brpn_i,
  input wire logic bat_vs_i,
  input wire logic bat_vp_i,
  input wire logic [1:0] bat_pp_i,
  // Translation cache load and invalidate
  input wire logic tc_we_i,
  input wire logic tc_data_i,
  input wire logic [31:0] tc_ea_i,
  input wire logic [`AUT_RPN_W-1:0] tc_rpn_i,
  input wire logic tc_chg_i,
  input wire logic [1:0] tc_pp_i,
  input wire logic tc_inv_i,
  input wire logic [31:0] tc_inv_ea_i
);
  // Block match and block address
  function automatic logic bat_match(input aut_pkg::aut_bat_t b, input logic [31:0] ea,
                                     input logic usr);
    return ((ea[31:`AUT_BLK_LO] & ~{4'h0, b.bl}) == b.bepi) && (usr ? b.vp : b.vs);
  endfunction
  function automatic logic [31:0] bat_pa(input aut_pkg::aut_bat_t b, input logic [31:0] ea);
    return {b.brpn | (ea[31:`AUT_BLK_LO] & {4'h0, b.bl}), ea[`AUT_BLK_LO-1:0]};
  endfunction
  // Access allowed by protection code
  function automatic logic prot_ok(input logic [1:0] pp, input logic usr, input logic st);
    logic ro;
    ro = (pp == `AUT_PP_RO) || (usr && pp == `AUT_PP_URO);
    return !(usr && pp == `AUT_PP_NONE) && !(st && ro);
  endfunction
  // Group address from a hash
  function automatic logic [31:0] grp_addr(input logic [`AUT_HASH_W-1:0] h,
                                           input logic [15:0] base,
                                           input logic [`AUT_HMASK_W-1:0] msk);
    return {base[15:9], base[8:0] | (h[18:10] & msk), h[9:0], {`AUT_GRP_LO{1'b0}}};
  endfunction

  logic [`AUT_VSID_W-1:0] seg_r [`AUT_SEG_CNT];
  logic [`AUT_VSID_W-1:0] seg_nxt [`AUT_SEG_CNT];
  aut_pkg::aut_bat_t ibat_r [`AUT_BAT_CNT];
  aut_pkg::aut_bat_t ibat_nxt [`AUT_BAT_CNT];
  aut_pkg::aut_bat_t dbat_r [`AUT_BAT_CNT];
  aut_pkg::aut_bat_t dbat_nxt [`AUT_BAT_CNT];
  logic [`AUT_BAT_CNT-1:0] ibat_sel;
  logic [`AUT_BAT_CNT-1:0] dbat_sel;
  logic [31:0] ibat_addr [`AUT_BAT_CNT];
  logic [31:0] dbat_addr [`AUT_BAT_CNT];
  logic [1:0] ibat_pp [`AUT_BAT_CNT];
  logic [1:0] dbat_pp [`AUT_BAT_CNT];
  logic [`AUT_VSID_W-1:0] i_vsid;
  logic [`AUT_VSID_W-1:0] d_vsid;
  logic itc_hit;
  logic dtc_hit;
  logic itc_chg;
  logic dtc_chg;
  logic [1:0] itc_pp;
  logic [1:0] dtc_pp;
  logic [`AUT_RPN_W-1:0] itc_rpn;
  logic [`AUT_RPN_W-1:0] dtc_rpn;
  logic tc_inv_ok;

  // Segment lookup forms the virtual segment id
  assign i_vsid = seg_r[fetch_ea_i[31:`AUT_SEG_LO]]; // [R8]
  assign d_vsid = seg_r[data_ea_i[31:`AUT_SEG_LO]];
  assign tc_inv_ok = tc_inv_i && !user_mode_i; // [R13]

  // Both translation caches
  aut_xlate_cache u_itc (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .lk_req_i(fetch_req_i && instr_xlate_en_i), .lk_vsid_i(i_vsid), .lk_ea_i(fetch_ea_i),
    .lk_hit_o(itc_hit), .lk_rpn_o(itc_rpn), .lk_chg_o(itc_chg), .lk_pp_o(itc_pp),
    .wr_i(tc_we_i && !tc_data_i), .wr_vsid_i(seg_r[tc_ea_i[31:`AUT_SEG_LO]]),
    .wr_ea_i(tc_ea_i), .wr_rpn_i(tc_rpn_i), .wr_chg_i(tc_chg_i), .wr_pp_i(tc_pp_i),
    .inv_i(tc_inv_ok), .inv_ea_i(tc_inv_ea_i)
  ); // [R11]
  aut_xlate_cache u_dtc (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .lk_req_i(data_req_i && data_xlate_en_i), .lk_vsid_i(d_vsid), .lk_ea_i(data_ea_i),
    .lk_hit_o(dtc_hit), .lk_rpn_o(dtc_rpn), .lk_chg_o(dtc_chg), .lk_pp_o(dtc_pp),
    .wr_i(tc_we_i && tc_data_i), .wr_vsid_i(seg_r[tc_ea_i[31:`AUT_SEG_LO]]),
    .wr_ea_i(tc_ea_i), .wr_rpn_i(tc_rpn_i), .wr_chg_i(tc_chg_i), .wr_pp_i(tc_pp_i),
    .inv_i(tc_inv_ok), .inv_ea_i(tc_inv_ea_i)
  ); // [R11]

  // Block compare per entry, both arrays
  genvar g;
  generate
    for (g = 0; g < `AUT_BAT_CNT; g++) begin : g_bat
      assign ibat_sel[g] = bat_match(ibat_r[g], fetch_ea_i, user_mode_i); // [R7]
      assign dbat_sel[g] = bat_match(dbat_r[g], data_ea_i, user_mode_i);
      assign ibat_addr[g] = bat_pa(ibat_r[g], fetch_ea_i);
      assign dbat_addr[g] = bat_pa(dbat_r[g], data_ea_i);
      assign ibat_pp[g] = ibat_r[g].pp;
      assign dbat_pp[g] = dbat_r[g].pp;
    end
  endgenerate

  // First matching entry of each array
  logic [31:0] ibat_pa_m;
  logic [31:0] dbat_pa_m;
  logic [1:0] ibat_pp_m;
  logic [1:0] dbat_pp_m;
  always_comb begin
    ibat_pa_m = `AUT_PA_RST;
    dbat_pa_m = `AUT_PA_RST;
    ibat_pp_m = `AUT_PP_NONE;
    dbat_pp_m = `AUT_PP_NONE;
    for (int k = `AUT_BAT_CNT - 1; k >= 0; k--) begin
      if (ibat_sel[k]) begin
        ibat_pa_m = ibat_addr[k];
        ibat_pp_m = ibat_pp[k];
      end
      if (dbat_sel[k]) begin
        dbat_pa_m = dbat_addr[k];
        dbat_pp_m = dbat_pp[k];
      end
    end
  end

  // Software loads of segments and block arrays
  always_comb begin
    seg_nxt = seg_r;
    ibat_nxt = ibat_r;
    dbat_nxt = dbat_r;
    if (seg_we_i) begin
      seg_nxt[seg_idx_i] = seg_vsid_i;
    end
    if (bat_we_i && !bat_data_i) begin
      ibat_nxt[bat_idx_i] = {bat_bepi_i, bat_bl_i, bat_brpn_i, bat_vs_i, bat_vp_i, bat_pp_i}; // [R14]
    end
    if (bat_we_i && bat_data_i) begin
      dbat_nxt[bat_idx_i] = {bat_bepi_i, bat_bl_i, bat_brpn_i, bat_vs_i, bat_vp_i, bat_pp_i}; // [R14]
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < `AUT_SEG_CNT; k++) begin
        seg_r[k] <= '0;
      end
      for (int k = 0; k < `AUT_BAT_CNT; k++) begin
        ibat_r[k] <= '0;
        dbat_r[k] <= '0;
      end
    end else begin
      seg_r <= seg_nxt;
      ibat_r <= ibat_nxt;
      dbat_r <= dbat_nxt;
    end
  end

  // Answer registers
  logic f_ack_r, f_ack_nxt, f_exc_r, f_exc_nxt;
  logic d_ack_r, d_ack_nxt, d_exc_r, d_exc_nxt;
  logic [31:0] f_pa_r, f_pa_nxt, d_pa_r, d_pa_nxt;
  aut_pkg::aut_vec_t f_vec_r, f_vec_nxt, d_vec_r, d_vec_nxt;

  // Fetch path: real mode, block, page, miss
  always_comb begin
    f_ack_nxt = 1'b0;
    f_exc_nxt = 1'b0;
    f_pa_nxt = f_pa_r;
    f_vec_nxt = f_vec_r;
    if (fetch_req_i) begin // [R2]
      if (!instr_xlate_en_i) begin
        f_ack_nxt = 1'b1; // [R5]
        f_pa_nxt = fetch_ea_i;
      end else if (|ibat_sel) begin
        f_ack_nxt = prot_ok(ibat_pp_m, user_mode_i, 1'b0); // [R18]
        f_exc_nxt = !f_ack_nxt; // [R1]
        f_pa_nxt = ibat_pa_m;
        f_vec_nxt = IPROT_VEC;
      end else if (itc_hit) begin
        f_ack_nxt = prot_ok(itc_pp, user_mode_i, 1'b0); // [R1]
        f_exc_nxt = !f_ack_nxt; // [R9]
        f_pa_nxt = {itc_rpn, fetch_ea_i[`AUT_EA_PG_LO-1:0]}; // [R6]
        f_vec_nxt = IPROT_VEC;
      end else begin
        f_exc_nxt = 1'b1; // [R15]
        f_vec_nxt = `AUT_VEC_IMISS;
      end
    end
  end

  // Data path: same order, stores check the change bit
  always_comb begin
    d_ack_nxt = 1'b0;
    d_exc_nxt = 1'b0;
    d_pa_nxt = d_pa_r;
    d_vec_nxt = d_vec_r;
    if (data_req_i) begin // [R2]
      if (!data_xlate_en_i) begin
        d_ack_nxt = 1'b1; // [R5]
        d_pa_nxt = data_ea_i;
      end else if (|dbat_sel) begin
        d_ack_nxt = prot_ok(dbat_pp_m, user_mode_i, data_store_i); // [R18]
        d_exc_nxt = !d_ack_nxt; // [R1]
        d_pa_nxt = dbat_pa_m;
        d_vec_nxt = DPROT_VEC;
      end else if (dtc_hit && !prot_ok(dtc_pp, user_mode_i, data_store_i)) begin
        d_exc_nxt = 1'b1; // [R9]
        d_vec_nxt = DPROT_VEC;
      end else if (dtc_hit && !(data_store_i && !dtc_chg)) begin
        d_ack_nxt = 1'b1; // [R10]
        d_pa_nxt = {dtc_rpn, data_ea_i[`AUT_EA_PG_LO-1:0]};
      end else begin
        d_exc_nxt = 1'b1; // [R9]
        d_vec_nxt = data_store_i ? `AUT_VEC_DSMISS : `AUT_VEC_DLMISS; // [R16] [R17]
      end
    end
  end

  // Search assist: hash of the missing page, data side first
  logic [`AUT_HASH_W-1:0] hash;
  logic d_miss;
  logic f_miss;
  logic [31:0] grp_pri_r, grp_pri_nxt, grp_sec_r, grp_sec_nxt;
  logic [`AUT_VA_W-1:0] miss_va_r, miss_va_nxt;
  aut_pkg::aut_src_t src_r, src_nxt;
  assign d_miss = d_exc_nxt && (d_vec_nxt != DPROT_VEC);
  assign f_miss = f_exc_nxt && (f_vec_nxt == `AUT_VEC_IMISS);
  always_comb begin
    logic [`AUT_VSID_W-1:0] vs;
    logic [31:0] ea;
    vs = d_miss ? d_vsid : i_vsid;
    ea = d_miss ? data_ea_i : fetch_ea_i;
    hash = vs[`AUT_HASH_W-1:0] ^ {3'h0, ea[`AUT_SEG_LO-1:`AUT_EA_PG_LO]}; // [R12]
    grp_pri_nxt = grp_pri_r;
    grp_sec_nxt = grp_sec_r;
    miss_va_nxt = miss_va_r;
    src_nxt = src_r;
    if (d_miss || f_miss) begin
      grp_pri_nxt = grp_addr(hash, htab_base_i, htab_mask_i); // [R3] [R4]
      grp_sec_nxt = grp_addr(~hash, htab_base_i, htab_mask_i); // [R12]
      miss_va_nxt = {vs, ea[`AUT_SEG_LO-1:0]}; // [R8]
      src_nxt = d_miss ? aut_pkg::AUT_SRC_DATA : aut_pkg::AUT_SRC_FETCH;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      f_ack_r <= 1'b0;
      f_exc_r <= 1'b0;
      f_pa_r <= `AUT_PA_RST;
      f_vec_r <= `AUT_VEC_RST;
      d_ack_r <= 1'b0;
      d_exc_r <= 1'b0;
      d_pa_r <= `AUT_PA_RST;
      d_vec_r <= `AUT_VEC_RST;
      grp_pri_r <= `AUT_PA_RST;
      grp_sec_r <= `AUT_PA_RST;
      miss_va_r <= '0;
      src_r <= aut_pkg::AUT_SRC_NONE;
    end else begin
      f_ack_r <= f_ack_nxt;
      f_exc_r <= f_exc_nxt;
      f_pa_r <= f_pa_nxt;
      f_vec_r <= f_vec_nxt;
      d_ack_r <= d_ack_nxt;
      d_exc_r <= d_exc_nxt;
      d_pa_r <= d_pa_nxt;
      d_vec_r <= d_vec_nxt;
      grp_pri_r <= grp_pri_nxt;
      grp_sec_r <= grp_sec_nxt;
      miss_va_r <= miss_va_nxt;
      src_r <= src_nxt;
    end
  end

  // Outputs straight from registers
  assign fetch_ack_o = f_ack_r;
  assign fetch_pa_o = f_pa_r;
  assign fetch_exc_o = f_exc_r;
  assign fetch_vec_o = f_vec_r;
  assign data_ack_o = d_ack_r;
  assign data_pa_o = d_pa_r;
  assign data_exc_o = d_exc_r;
  assign data_vec_o = d_vec_r;
  assign grp_pri_o = grp_pri_r;
  assign grp_sec_o = grp_sec_r;
  assign miss_va_o = miss_va_r;
  assign miss_from_data_o = (src_r == aut_pkg::AUT_SRC_DATA);

  // Checks on the answer timing and content
  property p_real_fetch;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (fetch_req_i && !instr_xlate_en_i) |=> (f_ack_r && f_pa_r == $past(fetch_ea_i));
  endproperty
  a_real_fetch: assert property (p_real_fetch) else $error("real mode fetch wrong"); // [R5]
  property p_no_req;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (!fetch_req_i && !data_req_i) |=> !(f_ack_r || f_exc_r || d_ack_r || d_exc_r);
  endproperty
  a_no_req: assert property (p_no_req) else $error("answer without request"); // [R2]
  property p_imiss;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (fetch_req_i && instr_xlate_en_i && !(|ibat_sel) && !itc_hit)
        |=> (f_exc_r && !f_ack_r && f_vec_r == `AUT_VEC_IMISS);
  endproperty
  a_imiss: assert property (p_imiss) else $error("fetch miss not raised"); // [R15]
  property p_dlmiss;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (data_req_i && !data_store_i && data_xlate_en_i && !(|dbat_sel) && !dtc_hit)
        |=> (d_exc_r && d_vec_r == `AUT_VEC_DLMISS);
  endproperty
  a_dlmiss: assert property (p_dlmiss) else $error("load miss not raised"); // [R16]
  property p_dschg;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (data_req_i && data_store_i && data_xlate_en_i && !(|dbat_sel) && dtc_hit && !dtc_chg
        && prot_ok(dtc_pp, user_mode_i, 1'b1)) |=> (d_exc_r && d_vec_r == `AUT_VEC_DSMISS);
  endproperty
  a_dschg: assert property (p_dschg) else $error("store change bit not trapped"); // [R17]
  property p_bat_first;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (fetch_req_i && instr_xlate_en_i && (|ibat_sel) && prot_ok(ibat_pp_m, user_mode_i, 1'b0))
        |=> (f_ack_r && !f_exc_r && f_pa_r == $past(ibat_pa_m));
  endproperty
  a_bat_first: assert property (p_bat_first) else $error("block result not used"); // [R18]
  property p_hit_time;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (data_req_i && data_xlate_en_i && !(|dbat_sel) && dtc_hit && !data_store_i
        && prot_ok(dtc_pp, user_mode_i, 1'b0))
        |=> (d_ack_r && d_pa_r[31:`AUT_EA_PG_LO] == $past(dtc_rpn));
  endproperty
  a_hit_time: assert property (p_hit_time) else $error("hit answer late or wrong"); // [R10]
  property p_grp;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (f_miss || d_miss) |=> (grp_pri_r[`AUT_GRP_LO-1:0] == '0
        && (grp_pri_r[15:`AUT_GRP_LO] ^ grp_sec_r[15:`AUT_GRP_LO]) == '1);
  endproperty
  a_grp: assert property (p_grp) else $error("group addresses malformed"); // [R4]
endmodule

// ===== aut_xlate_unit_tb_top.sv
module aut_xlate_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ixe = 1'b0, dxe = 1'b0, usr = 1'b0, bon;
  logic fr, dr, dst, fa, fe, da, de, mfd, sw, bw, bd, bvs, tw, td, tchg, ti;
  logic [31:0] fea, dea, fpa, dpa, gp, gs, tea, tiea;
  logic [19:0] fv, dv, trpn;
  logic [51:0] mva;
  logic [3:0] sidx;
  logic [23:0] svs;
  logic [1:0] bidx, bpp, tpp;
  logic [14:0] bepi, bbrpn;
  logic [10:0] bbl;
  logic [15:0] hbase = 16'h00a4;  // Table base aligned, mask zero
  int mismatches = 0, tests_run = 0;
  logic [22:0] tcm [logic [20:0]];
  logic [23:0] segm [16];
  // Clock
  always #4 sys_clk_i = ~sys_clk_i;
  aut_core_model i_aut_core_model (.sys_clk_i(sys_clk_i), .fetch_req_o(fr), .fetch_ea_o(fea),
    .data_req_o(dr), .data_store_o(dst), .data_ea_o(dea));
  aut_xlate_unit i_aut_xlate_unit (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .instr_xlate_en_i(ixe), .data_xlate_en_i(dxe), .user_mode_i(usr), .fetch_req_i(fr),
    .fetch_ea_i(fea), .fetch_ack_o(fa), .fetch_pa_o(fpa), .fetch_exc_o(fe), .fetch_vec_o(fv),
    .data_req_i(dr), .data_store_i(dst), .data_ea_i(dea), .data_ack_o(da), .data_pa_o(dpa),
    .data_exc_o(de), .data_vec_o(dv), .grp_pri_o(gp), .grp_sec_o(gs), .miss_va_o(mva),
    .miss_from_data_o(mfd), .seg_we_i(sw), .seg_idx_i(sidx), .seg_vsid_i(svs),
    .htab_base_i(hbase), .htab_mask_i(9'h000), .bat_we_i(bw), .bat_data_i(bd),
    .bat_idx_i(bidx), .bat_bepi_i(bepi), .bat_bl_i(bbl), .bat_brpn_i(bbrpn), .bat_vs_i(bvs),
    .bat_vp_i(1'b0), .bat_pp_i(bpp), .tc_we_i(tw), .tc_data_i(td), .tc_ea_i(tea),
    .tc_rpn_i(trpn), .tc_chg_i(tchg), .tc_pp_i(tpp), .tc_inv_i(ti), .tc_inv_ea_i(tiea));
  // Verdict and counts
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Compare one result
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, predicted by the model and compared in its answer cycle
  task automatic xreq(input bit d, input bit st, input logic [31:0] ea);
    logic [22:0] e;
    logic [18:0] h;
    logic [31:0] epa;
    logic [19:0] ev;
    logic [14:0] bm;
    bit hit;
    bm = {4'h0, bbl};
    h = segm[ea[31:28]][18:0] ^ {3'h0, ea[27:12]};
    hit = tcm.exists({d, ea[31:12]});
    e = hit ? tcm[{d, ea[31:12]}] : 23'h0;
    epa = {e[22:3], ea[11:0]};
    ev = 20'h0;
    if (!(d ? dxe : ixe)) epa = ea;
    else if (bon && !usr && (ea[31:17] & ~bm) == bepi)
      epa = {bbrpn | (ea[31:17] & bm), ea[16:0]};
    else if (!hit) ev = d ? (st ? 20'h01200 : 20'h01100) : 20'h01000;
    else if ((usr && e[1:0] == 2'h0) || (st && (e[1:0] == 2'h3 || (usr && e[1:0] == 2'h1))))
      ev = d ? 20'h00300 : 20'h00400;
    else if (st && !e[2]) ev = 20'h01200;
    i_aut_core_model.issue(d, st, ea);
    if (ev === 20'h0) chk(d ? {da, de, dpa} : {fa, fe, fpa}, {2'h2, epa});
    else chk(d ? {da, de, dv} : {fa, fe, fv}, {2'h1, ev});
    if (ev !== 20'h0 && !hit) begin
      chk({gp, gs}, {hbase, h[9:0], 6'h0, hbase, ~h[9:0], 6'h0});
      chk({mva, mfd}, {segm[ea[31:28]], ea[27:0], d});
    end
  endtask
  // Segment load with a random identifier
  task automatic seg(input logic [3:0] i);
    i_aut_core_model.idle();
    sidx = i;
    svs = 24'($urandom);
    sw = 1'b1;
    @(negedge sys_clk_i);
    sw = 1'b0;
    segm[i] = svs;
  endtask
  // Translation cache entry load
  task automatic tcl(input bit d, input logic [31:0] ea, input logic [1:0] pp, input bit chg);
    i_aut_core_model.idle();
    {td, tea, tpp, tchg, tw} = {d, ea, pp, chg, 1'b1};
    trpn = 20'($urandom);
    @(negedge sys_clk_i);
    tw = 1'b0;
    tcm[{d, ea[31:12]}] = {trpn, chg, pp};
  endtask
  // Selective invalidate, ignored in user mode
  task automatic inv(input logic [31:0] ea);
    i_aut_core_model.idle();
    tiea = ea;
    ti = 1'b1;
    @(negedge sys_clk_i);
    ti = 1'b0;
    if (!usr) tcm.delete({1'b1, ea[31:12]});
  endtask
  // Hang guard
  initial begin
    #200us;
    mismatches++;
    wrap_up();
  end
  // Main sequence
  initial begin
    void'($urandom(54445));
    {sw, bw, bd, bvs, tw, td, tchg, ti, bon} = '0;
    {sidx, svs, bidx, bpp, bepi, bbl, bbrpn, tea, trpn, tpp, tiea} = '0;
    segm = '{default: 24'h0};
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) begin
      xreq(1'b0, 1'b0, $urandom);
      xreq(1'b1, 1'($urandom), $urandom);
    end
    ixe = 1'b1;
    dxe = 1'b1;
    seg(4'h1);
    seg(4'h7);
    for (int i = 0; i < 6; i++) xreq(i > 1, i > 3, {i[0] ? 4'h7 : 4'h1, 28'($urandom)});
    tcl(1'b0, 32'h1000_3000, 2'h2, 1'b1);
    tcl(1'b1, 32'h7000_4000, 2'h2, 1'b0);
    tcl(1'b1, 32'h1000_5000, 2'h0, 1'b1);
    tcl(1'b1, 32'h1002_1000, 2'h2, 1'b1);
    xreq(1'b0, 1'b0, 32'h1000_3abc);
    xreq(1'b1, 1'b0, 32'h7000_4123);
    xreq(1'b1, 1'b1, 32'h7000_4123);
    xreq(1'b1, 1'b1, 32'h1000_5010);
    xreq(1'b0, 1'b0, 32'h7000_4000);
    usr = 1'b1;
    xreq(1'b1, 1'b0, 32'h1000_5010);
    xreq(1'b0, 1'b0, 32'h1000_3000);
    inv(32'h7000_4000);
    xreq(1'b1, 1'b0, 32'h7000_4000);
    usr = 1'b0;
    inv(32'h7000_4000);
    xreq(1'b1, 1'b0, 32'h7000_4000);
    xreq(1'b0, 1'b0, 32'h1000_3000);
    // Block entry of 512 Kbyte in both arrays, over the cached pages
    i_aut_core_model.idle();
    {bidx, bepi, bbl, bbrpn, bvs, bpp, bd, bw} = {2'h2, 15'h0800, 11'h003, 15'h2a40, 1'b1, 2'h2, 2'h3};
    @(negedge sys_clk_i);
    bd = 1'b0;  // Same entry into the instruction array
    @(negedge sys_clk_i);
    bw = 1'b0;
    bon = 1'b1;
    repeat (4) xreq(1'b1, 1'($urandom), {15'h0800 | 15'($urandom % 4), 17'($urandom)});
    xreq(1'b1, 1'b0, 32'h1002_1abc);
    xreq(1'b0, 1'b0, 32'h1002_1abc);
    usr = 1'b1;
    xreq(1'b1, 1'b0, 32'h1000_5010);
    dxe = 1'b0;
    xreq(1'b1, 1'b1, 32'h1000_5010);
    i_aut_core_model.idle();
    repeat (2) @(negedge sys_clk_i);
    wrap_up();
  end
endmodule
